/* File: reset_source_sequencer_cfg.svh */
`ifndef RESET_SOURCE_SEQUENCER_CFG_SVH
`define RESET_SOURCE_SEQUENCER_CFG_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define RSS_ADDR_W         4
`define RSS_ADDR_STATUS    4'h0
`define RSS_ADDR_CLOCK     4'h1
`define RSS_ADDR_CONTROL   4'h2
// ----------------------------------------
// reset cause status bit positions
// ----------------------------------------
`define RSS_BIT_POR        0
`define RSS_BIT_BOR        1
`define RSS_BIT_IDLE       2
`define RSS_BIT_SLEEP      3
`define RSS_BIT_WATCHDOG_TIMEOUT_FLAG       4
`define RSS_BIT_SWR        6
`define RSS_BIT_EXTERNAL_RESET_FLAG       7
`define RSS_BIT_IOP        14
`define RSS_BIT_TRAP       15
`define RSS_STATUS_MASK    16'hC0DF
`define RSS_STATUS_POR_VAL 16'h0003
// ----------------------------------------
// clock control status bits
// ----------------------------------------
`define RSS_BIT_CF         3
`define RSS_BIT_LOCK       5
// ----------------------------------------
// vectors
// ----------------------------------------
`define RSS_VEC_RESET      24'h000000
`define RSS_VEC_CLKFAIL    24'h000004
`define RSS_FRC_SEL        3'h1
// ----------------------------------------
// timing (100 MHz clock, 10 ns)
// ----------------------------------------
`define RSS_CLK_NS         10
`define RSS_BIAS_SETTLE_DELAY_US        10
`define RSS_MONITOR_START_DELAY_US       100
`define RSS_BIAS_SETTLE_DELAY_CYC       ((`RSS_BIAS_SETTLE_DELAY_US * 1000) / `RSS_CLK_NS)
`define RSS_MONITOR_START_DELAY_CYC      ((`RSS_MONITOR_START_DELAY_US * 1000) / `RSS_CLK_NS)
`define RSS_PWRT4_MS       4
`define RSS_PWRT16_MS      16
`define RSS_PWRT64_MS      64
`define RSS_MS_CYC         (1000000 / `RSS_CLK_NS)
`define RSS_GLITCH_CYC     8'h10
`define RSS_Q_PHASES       2'h3
`define RSS_CNT_W          24
`endif

/* File: reset_source_sequencer_pkg.sv */
package reset_source_sequencer_pkg;
  typedef enum logic [4:0] {
    ST_HOLD   = 5'b00001,
    ST_BIAS   = 5'b00010,
    ST_POWER_UP_TIMER   = 5'b00100,
    ST_CLKW   = 5'b01000,
    ST_RUN    = 5'b10000
  } seq_state_e;
endpackage : reset_source_sequencer_pkg

/* File: reset_source_sequencer.sv */
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "reset_source_sequencer_cfg.svh"
module reset_source_sequencer
  import reset_source_sequencer_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic                   i_por_pulse,
  input  wire logic                   i_bor_detect,
  input  wire logic                   i_bor_enable,
  input  wire logic                   i_external_reset_pin_n,
  input  wire logic                   i_reset_instr,
  input  wire logic                   i_wdt_timeout,
  input  wire logic                   i_trap_lockup,
  input  wire logic                   i_illegal_op,
  input  wire logic                   i_int_wake,
  input  wire logic [23:0]            i_int_vector,
  input  wire logic                   i_in_sleep,
  input  wire logic                   i_in_idle,
  input  wire logic [23:0]            i_next_pc,
  input  wire logic [2:0]             i_oscillator_group_config,
  input  wire logic [4:0]             i_primary_mode_config,
  input  wire logic [1:0]             i_power_up_timer_select,
  input  wire logic                   i_fail_safe_monitor_en,
  input  wire logic                   i_crystal_mode,
  input  wire logic                   i_pll_used,
  input  wire logic                   i_osc_started,
  input  wire logic                   i_ost_expired,
  input  wire logic                   i_pll_locked,
  input  wire logic                   i_sysclk_toggle,
  input  wire logic [`RSS_ADDR_W-1:0] i_addr,
  input  wire logic [15:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [15:0]                 o_rdata,
  output logic                        o_internal_system_reset,
  output logic                        o_pc_load,
  output logic [23:0]                 o_pc_value,
  output logic                        o_clock_fail_trap,
  output logic [2:0]                  o_clock_select,
  output logic                        o_ost_start,
  output logic                        o_pin_out,
  output logic                        o_pin_oe
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] pin_sync;
  logic [1:0] bor_sync;
  logic [1:0] osc_sync;
  logic [1:0] ost_sync;
  logic [1:0] lock_sync;
  logic [1:0] tog_sync;

  always_ff @(posedge i_mclk) begin
    pin_sync  <= {pin_sync[0], i_external_reset_pin_n};
    bor_sync  <= {bor_sync[0], i_bor_detect & i_bor_enable};
    osc_sync  <= {osc_sync[0], i_osc_started};
    ost_sync  <= {ost_sync[0], i_ost_expired};
    lock_sync <= {lock_sync[0], i_pll_locked};
    tog_sync  <= {tog_sync[0], i_sysclk_toggle};
  end

  // ----------------------------------------
  // pin glitch filter
  // ----------------------------------------
  logic [7:0] glitch_cnt;
  logic       pin_low;
  logic       pin_low_d;
  logic       ext_evt;

  // a level must hold for the whole window, short pulses only restart the count
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      glitch_cnt <= 8'h00;
      pin_low    <= 1'b0;
      pin_low_d  <= 1'b0;
    end else begin
      pin_low_d <= pin_low;
      if (pin_sync[1] == !pin_low) begin
        glitch_cnt <= 8'h00;
      end else if (glitch_cnt == `RSS_GLITCH_CYC) begin
        pin_low    <= ~pin_low;
        glitch_cnt <= 8'h00;
      end else begin
        glitch_cnt <= glitch_cnt + 8'h01;
      end
    end
  end
  assign ext_evt = pin_low & ~pin_low_d;

  // the pin is input only: internal causes never pull it
  always_ff @(posedge i_mclk) begin
    o_pin_out <= 1'b1;
    o_pin_oe  <= 1'b0;
  end

  // ----------------------------------------
  // event edges
  // ----------------------------------------
  logic bor_d;
  logic bor_evt;
  logic run_mode;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bor_d <= 1'b0;
    end else begin
      bor_d <= bor_sync[1];
    end
  end
  assign bor_evt  = bor_sync[1] & ~bor_d;
  assign run_mode = ~i_in_sleep & ~i_in_idle;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // reads and writes share one decoder so the map cannot drift apart
  function automatic logic addr_is(input logic [`RSS_ADDR_W-1:0] a, input logic [`RSS_ADDR_W-1:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  logic wr_status;
  logic wr_clock;

  assign wr_status = i_wr && addr_is(i_addr, `RSS_ADDR_STATUS);
  assign wr_clock  = i_wr && addr_is(i_addr, `RSS_ADDR_CLOCK);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  seq_state_e          state;
  seq_state_e          next_state;
  logic [`RSS_CNT_W-1:0] cnt;
  logic [`RSS_CNT_W-1:0] power_up_timer_cyc;
  logic [1:0]          q_phase;
  logic                any_reset;
  logic                clk_ready;
  logic                was_bor;

  function automatic logic [`RSS_CNT_W-1:0] ms_to_cyc(input logic [1:0] sel);
    case (sel)
      2'h1:    ms_to_cyc = `RSS_CNT_W'(`RSS_PWRT4_MS * `RSS_MS_CYC);
      2'h2:    ms_to_cyc = `RSS_CNT_W'(`RSS_PWRT16_MS * `RSS_MS_CYC);
      2'h3:    ms_to_cyc = `RSS_CNT_W'(`RSS_PWRT64_MS * `RSS_MS_CYC);
      default: ms_to_cyc = '0;
    endcase
  endfunction : ms_to_cyc

  // the longest timeout is millions of cycles, so the counter is sized for it
  always_comb begin
    power_up_timer_cyc = ms_to_cyc(i_power_up_timer_select);
    if (power_up_timer_cyc == '0 && was_bor && i_crystal_mode) begin
      power_up_timer_cyc = `RSS_CNT_W'(`RSS_MONITOR_START_DELAY_CYC);
    end
  end

  assign any_reset = i_por_pulse | bor_evt | ext_evt | i_reset_instr
                   | (i_wdt_timeout & run_mode) | i_trap_lockup | i_illegal_op;

  // every source must be started and toggling; crystal also waits for its start timer, PLL for lock
  assign clk_ready = osc_sync[1] & tog_sync[1]
                   & (~i_crystal_mode | ost_sync[1]) & (~i_pll_used | lock_sync[1]);

  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: next_state = ST_BIAS;
      ST_BIAS: if (cnt == `RSS_CNT_W'(`RSS_BIAS_SETTLE_DELAY_CYC - 1)) next_state = ST_POWER_UP_TIMER;
      ST_POWER_UP_TIMER: if (cnt >= power_up_timer_cyc) next_state = ST_CLKW;
      ST_CLKW: begin
        if (q_phase == 2'h0 && (clk_ready || i_fail_safe_monitor_en)) next_state = ST_RUN;
      end
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_por_pulse || any_reset) begin
      state <= ST_HOLD;
      cnt   <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        cnt <= '0;
      end else if (state == ST_BIAS || state == ST_POWER_UP_TIMER) begin
        cnt <= cnt + `RSS_CNT_W'(1);
      end
    end
  end

  // free-running phase count marks the first phase edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q_phase <= 2'h0;
    end else begin
      q_phase <= (q_phase == `RSS_Q_PHASES) ? 2'h0 : q_phase + 2'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_por_pulse) begin
      was_bor <= 1'b0;
    end else if (bor_evt) begin
      was_bor <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ost_start <= 1'b0;
    end else begin
      o_ost_start <= (i_por_pulse | bor_evt) & i_crystal_mode;
    end
  end

  // ----------------------------------------
  // clock select, fail trap, program counter
  // ----------------------------------------
  logic cf_flag;
  logic release_evt;

  // a reset in the release cycle wins, so no vector load races the restart
  assign release_evt = (state == ST_CLKW) && (next_state == ST_RUN) && !any_reset;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_clock_select <= 3'h0;
    end else if (release_evt && !clk_ready) begin
      o_clock_select <= `RSS_FRC_SEL;
    end else if (i_por_pulse || bor_evt) begin
      o_clock_select <= i_oscillator_group_config;
    end
  end

  // a trap in the cycle of a software clear keeps the flag set
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cf_flag <= 1'b0;
    end else if (release_evt && !clk_ready) begin
      cf_flag <= 1'b1;
    end else if (wr_clock && !i_wdata[`RSS_BIT_CF]) begin
      cf_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_internal_system_reset <= 1'b1;
      o_clock_fail_trap       <= 1'b0;
      o_pc_load               <= 1'b0;
      o_pc_value              <= `RSS_VEC_RESET;
    end else begin
      o_clock_fail_trap <= 1'b0;
      o_pc_load         <= 1'b0;
      // frozen at the reset vector while no clock and no monitor
      o_internal_system_reset <= any_reset || ((state != ST_RUN) && !release_evt);
      if (release_evt) begin
        o_pc_load  <= 1'b1;
        o_pc_value <= `RSS_VEC_RESET;
        if (!clk_ready) begin
          o_clock_fail_trap <= 1'b1;
          o_pc_value        <= `RSS_VEC_CLKFAIL;
        end
      end else if (state == ST_RUN && i_int_wake) begin
        o_pc_load  <= 1'b1;
        o_pc_value <= i_int_vector;
      end else if (state == ST_RUN && i_wdt_timeout && !run_mode) begin
        o_pc_load  <= 1'b1;
        o_pc_value <= i_next_pc;
      end
    end
  end

  // ----------------------------------------
  // reset cause status
  // ----------------------------------------
  logic [15:0] reset_cause_status;
  logic [15:0] next_status;

  always_comb begin
    next_status = reset_cause_status;
    if (wr_status) begin
      next_status = i_wdata & `RSS_STATUS_MASK;
    end
    // hardware events below override a same-cycle software write
    if (i_trap_lockup) next_status[`RSS_BIT_TRAP] = 1'b1;
    if (i_illegal_op) next_status[`RSS_BIT_IOP] = 1'b1;
    if (i_int_wake && i_in_sleep) next_status[`RSS_BIT_SLEEP] = 1'b1;
    if (i_wdt_timeout) begin
      next_status[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      if (run_mode) begin
        next_status[`RSS_BIT_EXTERNAL_RESET_FLAG]  = 1'b0;
        next_status[`RSS_BIT_SWR]   = 1'b0;
        next_status[`RSS_BIT_IDLE]  = 1'b0;
        next_status[`RSS_BIT_SLEEP] = 1'b0;
      end else begin
        next_status[`RSS_BIT_SLEEP] = i_in_sleep;
        next_status[`RSS_BIT_IDLE]  = next_status[`RSS_BIT_IDLE] | i_in_idle;
      end
    end
    if (i_reset_instr) begin
      next_status[`RSS_BIT_SWR]   = 1'b1;
      next_status[`RSS_BIT_EXTERNAL_RESET_FLAG]  = 1'b0;
      next_status[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      next_status[`RSS_BIT_IDLE]  = 1'b0;
      next_status[`RSS_BIT_SLEEP] = 1'b0;
    end
    if (ext_evt) begin
      next_status[`RSS_BIT_EXTERNAL_RESET_FLAG]  = 1'b1;
      next_status[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      next_status[`RSS_BIT_SLEEP] = i_in_sleep;
      next_status[`RSS_BIT_IDLE]  = i_in_idle;
      if (run_mode) next_status[`RSS_BIT_SWR] = 1'b0;
    end
    if (bor_evt) begin
      next_status[`RSS_BIT_BOR] = 1'b1;
      next_status[`RSS_BIT_POR] = 1'b0;
    end
    if (i_por_pulse) next_status = `RSS_STATUS_POR_VAL;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      reset_cause_status <= `RSS_STATUS_POR_VAL;
    end else begin
      reset_cause_status <= next_status;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      if (addr_is(i_addr, `RSS_ADDR_STATUS)) begin
        o_rdata <= reset_cause_status;
      end else if (addr_is(i_addr, `RSS_ADDR_CLOCK)) begin
        o_rdata <= {1'b0, o_clock_select, 6'h00, lock_sync[1], 1'b0, cf_flag, 3'h0};
      end else if (addr_is(i_addr, `RSS_ADDR_CONTROL)) begin
        o_rdata <= {3'h0, i_primary_mode_config, 3'h0, i_oscillator_group_config, state == ST_RUN, was_bor};
      end else begin
        o_rdata <= 16'h0000;
      end
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule : reset_source_sequencer

/* File: clock_source_model.sv */
`timescale 1ns/100ps
module clock_source_model (
  input  wire logic i_mclk,
  input  wire logic i_osc_run,
  input  wire logic i_slow,
  input  wire logic i_ost_start,
  output logic      o_osc_started,
  output logic      o_ost_expired,
  output logic      o_pll_locked,
  output logic      o_sysclk_toggle
);
  // ----------------------------------------
  // oscillator, start timer and pll lock
  // ----------------------------------------
  logic [7:0] ost_cnt;
  assign o_osc_started   = i_osc_run;
  assign o_sysclk_toggle = i_osc_run;
  // a dead oscillator never expires its start timer, slow one takes 200 cycles
  always_ff @(posedge i_mclk) begin
    if (!i_osc_run) begin
      ost_cnt       <= 8'h00;
      o_ost_expired <= 1'b0;
    end else if (i_ost_start) begin
      ost_cnt       <= i_slow ? 8'hC8 : 8'h04;
      o_ost_expired <= 1'b0;
    end else if (ost_cnt != 8'h00) begin
      ost_cnt <= ost_cnt - 8'h01;
    end else begin
      o_ost_expired <= 1'b1;
    end
  end
  // lock lags the start timer by a cycle
  always_ff @(posedge i_mclk) begin
    o_pll_locked <= o_ost_expired;
  end
endmodule : clock_source_model

/* File: reset_source_sequencer_props.sv */
`timescale 1ns/100ps
module reset_source_sequencer_props (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_por_pulse,
  input wire logic        i_fail_safe_monitor_en,
  input wire logic        i_sysclk_toggle,
  input wire logic        o_internal_system_reset,
  input wire logic        o_pc_load,
  input wire logic [23:0] o_pc_value,
  input wire logic        o_clock_fail_trap,
  input wire logic [2:0]  o_clock_select,
  input wire logic        o_pin_out,
  input wire logic        o_pin_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // cycles since the last power-on pulse
  // ----------------------------------------
  logic [11:0] since_por;
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_por_pulse)
      since_por <= 12'h000;
    else if (since_por != 12'hFFF)
      since_por <= since_por + 12'h001;
  end
  sequence s_release;
    $fell(o_internal_system_reset);
  endsequence
  sequence s_vec_load;
    o_pc_load && (o_pc_value == 24'h000000 || o_pc_value == 24'h000004);
  endsequence
  sequence s_fail_load;
    o_pc_load && o_pc_value == 24'h000004;
  endsequence
  a_pin_never_driven: assert property (!o_pin_oe && o_pin_out)
    else $error("reset pin driven");
  a_release_after_bias: assert property (s_release |-> since_por >= 12'h3E8)
    else $error("reset released before bias delay");
  a_release_loads_vec: assert property (s_release |-> ##[0:2] s_vec_load)
    else $error("release without vector load");
  a_trap_fast_rc: assert property (o_clock_fail_trap |-> s_fail_load ##[0:2] (o_clock_select == 3'h1))
    else $error("clock fail trap without vector or fast rc");
  a_trap_one_cycle: assert property (o_clock_fail_trap |=> !o_clock_fail_trap)
    else $error("clock fail trap longer than a cycle");
  a_por_enters_reset: assert property (i_por_pulse |=> ##1 o_internal_system_reset [*8])
    else $error("power-on pulse did not hold reset");
  a_frozen_no_clock: assert property (
    (!i_fail_safe_monitor_en && !i_sysclk_toggle) [*4] ##0 o_internal_system_reset
      |=> o_internal_system_reset)
    else $error("released without a running clock");
  a_pc_load_pulse: assert property (o_pc_load |=> !o_pc_load)
    else $error("program counter load longer than a cycle");
endmodule : reset_source_sequencer_props

/* File: reset_source_sequencer_bench.sv */
`timescale 1ns/100ps
`include "reset_source_sequencer_cfg.svh"
module reset_source_sequencer_bench;
  logic        i_mclk, i_rst, i_por_pulse, i_bor_detect, i_bor_enable, i_external_reset_pin_n;
  logic        i_reset_instr, i_wdt_timeout, i_trap_lockup, i_illegal_op, i_int_wake, i_in_sleep, i_in_idle;
  logic        i_fail_safe_monitor_en, i_crystal_mode, i_pll_used, i_osc_started, i_ost_expired, i_pll_locked;
  logic        i_sysclk_toggle, i_wr, i_rd, o_internal_system_reset, o_pc_load, o_clock_fail_trap;
  logic        o_ost_start, o_pin_out, o_pin_oe, osc_run, osc_slow, ost_seen;
  logic [23:0] i_int_vector, i_next_pc, o_pc_value, pc;
  logic [15:0] i_wdata, o_rdata, v;
  logic [4:0]  i_primary_mode_config;
  logic [3:0]  i_addr;
  logic [2:0]  i_oscillator_group_config, o_clock_select;
  logic [1:0]  i_power_up_timer_select;
  logic        trap;
  int          err_total, checks_done, cyc;
  reset_source_sequencer dut (.*);
  clock_source_model partner (
    .i_mclk          (i_mclk),
    .i_osc_run       (osc_run),
    .i_slow          (osc_slow),
    .i_ost_start     (o_ost_start),
    .o_osc_started   (i_osc_started),
    .o_ost_expired   (i_ost_expired),
    .o_pll_locked    (i_pll_locked),
    .o_sysclk_toggle (i_sysclk_toggle)
  );
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (o_ost_start === 1'b1)
      ost_seen <= 1'b1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    v = o_rdata;
    @(posedge i_mclk);
  endtask : rd
  // bounded wait for the vector load, counting cycles
  task automatic wait_load(input int lim);
    cyc = 0;
    @(negedge i_mclk);
    while (o_pc_load !== 1'b1 && cyc < lim) begin
      @(negedge i_mclk);
      cyc++;
    end
    if (cyc >= lim) begin
      err_total++;
      print_verdict();
    end
    pc   = o_pc_value;
    trap = o_clock_fail_trap;
    @(posedge i_mclk);
  endtask : wait_load
  task automatic fire(input int k);
    case (k)
      0: i_reset_instr <= 1'b1;
      1: i_wdt_timeout <= 1'b1;
      2: i_trap_lockup <= 1'b1;
      3: i_illegal_op <= 1'b1;
      4: i_external_reset_pin_n <= 1'b0;
      5: i_int_wake <= 1'b1;
      default: i_por_pulse <= 1'b1;
    endcase
    if (k == 4)
      repeat (40) @(posedge i_mclk);
    @(posedge i_mclk);
    {i_reset_instr, i_wdt_timeout, i_trap_lockup, i_illegal_op, i_int_wake, i_por_pulse} <= 6'h00;
    i_external_reset_pin_n <= 1'b1;
  endtask : fire
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_on();
    fire(6);
    wait_load(3000);
    check("bias", {23'h0, cyc >= 1000 && cyc < 1100}, 24'h1);
    check("vector", pc, 24'h000000);
    check("select", {21'h0, o_clock_select}, {21'h0, i_oscillator_group_config});
    rd(`RSS_ADDR_STATUS);
    check("status", {8'h00, v}, 24'h000003);
  endtask : t_power_on
  task automatic t_bus();
    wr(`RSS_ADDR_STATUS, 16'hFFFF);
    rd(`RSS_ADDR_STATUS);
    check("mask", {8'h00, v}, 24'h00C0DF);
    wr(4'hF, 16'h1234);
    rd(4'hF);
    check("unmapped", {8'h00, v}, 24'h000000);
    rd(`RSS_ADDR_CLOCK);
    check("lock", {23'h0, v[`RSS_BIT_LOCK]}, 24'h1);
    rd(`RSS_ADDR_CONTROL);
    check("control", {8'h00, v}, 24'h00050E);
  endtask : t_bus
  task automatic t_causes();
    int          kind [9] = '{0, 1, 2, 3, 4, 4, 4, 1, 5};
    int          pwr  [9] = '{0, 0, 0, 0, 0, 2, 1, 2, 2};
    logic [15:0] from [9] = '{16'hC0DF, 16'hC0DF, 16'h00DF, 16'h80DF, 16'hC0DF, 16'h0057, 16'h005B,
                              16'hC0C3, 16'h0000};
    logic [15:0] want [9] = '{16'hC043, 16'hC013, 16'h80DF, 16'hC0DF, 16'hC083, 16'h00CB, 16'h00C7,
                              16'hC0DB, 16'h0008};
    for (int i = 0; i < 9; i++) begin
      wr(`RSS_ADDR_STATUS, from[i]);
      {i_in_sleep, i_in_idle} <= pwr[i][1:0];
      fire(kind[i]);
      {i_in_sleep, i_in_idle} <= 2'h0;
      wait_load(5000);
      check("pc", pc, kind[i] == 5 ? i_int_vector : (kind[i] == 1 && pwr[i] == 2) ? i_next_pc : 24'h0);
      rd(`RSS_ADDR_STATUS);
      check("cause", {8'h00, v}, {8'h00, want[i]});
    end
  endtask : t_causes
  task automatic t_glitch();
    wr(`RSS_ADDR_STATUS, 16'h0000);
    i_external_reset_pin_n <= 1'b0;
    repeat (8) @(posedge i_mclk);
    i_external_reset_pin_n <= 1'b1;
    repeat (60) @(posedge i_mclk);
    rd(`RSS_ADDR_STATUS);
    check("glitch", {7'h0, o_internal_system_reset, v}, 24'h0);
    check("pin", {22'h0, o_pin_oe, o_pin_out}, 24'h1);
  endtask : t_glitch
  task automatic t_frozen();
    osc_run <= 1'b0;
    fire(6);
    repeat (1500) @(posedge i_mclk);
    check("frozen", {23'h0, o_internal_system_reset}, 24'h1);
    osc_run <= 1'b1;
    wait_load(300);
    check("late pc", pc, 24'h000000);
  endtask : t_frozen
  task automatic t_fail();
    {i_fail_safe_monitor_en, i_crystal_mode, i_pll_used, osc_run} <= 4'hE;
    fire(6);
    wait_load(3000);
    check("trap", {23'h0, trap}, 24'h1);
    check("trap pc", pc, 24'h000004);
    rd(`RSS_ADDR_CLOCK);
    check("clock", {20'h0, v[14:12], v[3]}, 24'h3);
    wr(`RSS_ADDR_CLOCK, 16'h0000);
    rd(`RSS_ADDR_CLOCK);
    check("fail clear", {23'h0, v[`RSS_BIT_CF]}, 24'h0);
    {i_fail_safe_monitor_en, i_crystal_mode, i_pll_used, osc_run} <= 4'h1;
  endtask : t_fail
  task automatic t_brown();
    {i_crystal_mode, i_pll_used, osc_slow, i_in_sleep} <= 4'hF;
    wr(`RSS_ADDR_STATUS, 16'hC0DD);
    ost_seen     = 1'b0;
    i_bor_detect <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_bor_detect <= 1'b0;
    wait_load(20000);
    check("bor delay", {23'h0, cyc >= `RSS_BIAS_SETTLE_DELAY_CYC + `RSS_MONITOR_START_DELAY_CYC
                               && cyc < `RSS_BIAS_SETTLE_DELAY_CYC + `RSS_MONITOR_START_DELAY_CYC + 100}, 24'h1);
    check("bor select", {21'h0, o_clock_select}, {21'h0, i_oscillator_group_config});
    check("ost", {23'h0, ost_seen}, 24'h1);
    rd(`RSS_ADDR_STATUS);
    check("bor flags", {8'h00, v}, 24'h00C0DE);
  endtask : t_brown
  initial begin
    {i_por_pulse, i_bor_detect, i_reset_instr, i_wdt_timeout, i_trap_lockup, i_illegal_op} = 6'h00;
    {i_int_wake, i_in_sleep, i_in_idle, i_fail_safe_monitor_en, i_crystal_mode, i_pll_used} = 6'h00;
    {i_wr, i_rd, osc_slow, ost_seen} = 4'h0;
    {i_bor_enable, i_external_reset_pin_n, osc_run, i_rst} = 4'hF;
    {i_int_vector, i_next_pc} = {24'h000044, 24'h000122};
    {i_addr, i_wdata, i_power_up_timer_select} = 22'h0;
    {i_oscillator_group_config, i_primary_mode_config} = {3'h3, 5'h05};
    err_total = 0;
    checks_done = 0;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_power_on();
    t_bus();
    t_causes();
    t_glitch();
    t_frozen();
    t_fail();
    t_brown();
    print_verdict();
  end
endmodule : reset_source_sequencer_bench
bind reset_source_sequencer reset_source_sequencer_props u_props (.*);
